// ---- core_fetch.sv ----
// Processor core stand-in that fetches from the presented vector word address.
// Assumes the request outputs are registered on pclk.
`timescale 1ns/10ps
`default_nettype none
module core_fetch (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic irq_req,
    input wire logic [ivm_pkg::WAD_W-1:0] irq_word_addr,
    output logic [ivm_pkg::WAD_W-1:0] fetch_addr
);
    // Never acknowledges: the block has no accept path, so a request ends on a flag clear or when its enable or the global gate is dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_addr <= 7'h7F;
        end else if (irq_req) begin
            fetch_addr <= irq_word_addr;
        end
    end
endmodule : core_fetch
`default_nettype wire

// ---- interrupt_vector_mapping.sv ----
// Interrupt flags, enables, request gating and vector selection.
// Source events are one-cycle pulses from logic on pclk; no synchroniser.
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module interrupt_vector_mapping #(
    parameter int N_VEC = ivm_pkg::N_VEC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ivm_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [N_VEC-1:0] evt_in,
    input wire logic [ivm_pkg::TA_NUM-1:0] timer_a0_split_evt,
    input wire logic [ivm_pkg::TA_NUM-1:0] timer_a1_split_evt,
    input wire logic memory_scan_checker,
    input wire logic clock_failure_detector,
    output logic irq_req,
    output logic [ivm_pkg::IDX_W-1:0] irq_vector,
    output logic [ivm_pkg::WAD_W-1:0] irq_word_addr
);
    localparam int VW = ivm_pkg::VEC_W;
    localparam int IW = ivm_pkg::IDX_W;
    localparam int AW = ivm_pkg::WAD_W;
    localparam int WD = ivm_pkg::WORD;

    typedef struct packed {
        logic ge;
        logic sp0;
        logic sp1;
        logic ovr;
        logic [IW-1:0] pv;
        logic [VW-1:0] en;
        logic [VW-1:0] flg;
        logic req;
        logic [IW-1:0] vec;
        logic [AW-1:0] wad;
        logic [31:0] rd;
        logic err;
    } state_s;

    state_s s_r;
    state_s s_nxt;

    logic [VW-1:0] vld;
    logic [VW-1:0] ev;
    logic [VW-1:0] ena;
    logic [VW-1:0] pend_cur;
    logic [VW-1:0] gate;
    logic [VW-1:0] clr;
    logic found;
    logic [IW-1:0] low_idx;
    logic [IW-1:0] vec_sel;
    logic nmi_src;
    logic setup;
    logic acc_wr;
    logic hit;

    assign nmi_src = memory_scan_checker | clock_failure_detector;
    assign setup = psel & ~penable;
    assign acc_wr = psel & penable & pwrite;
    assign hit = (paddr == ivm_pkg::OFS_CTRL) || (paddr == ivm_pkg::OFS_EN_LO) ||
        (paddr == ivm_pkg::OFS_EN_HI) || (paddr == ivm_pkg::OFS_FLG_LO) ||
        (paddr == ivm_pkg::OFS_FLG_HI) || (paddr == ivm_pkg::OFS_STAT);

    // Per vector: ownership, event source and effective enable
    for (genvar i = 0; i < VW; i++) begin : g_vec
        if (i >= N_VEC || i == ivm_pkg::VEC_RESET) begin : g_none
            // Reset entry is not a request and vectors past the table do not exist
            assign vld[i] = 1'b0;
            assign ev[i] = 1'b0;
            assign ena[i] = 1'b0;
            assign gate[i] = 1'b0;
        end else if (i == ivm_pkg::VEC_NMI) begin : g_nmi
            assign vld[i] = 1'b1;
            assign ev[i] = nmi_src;
            // Non-maskable: no enable and no global gate
            assign ena[i] = 1'b1;
            assign gate[i] = 1'b1;
        end else if (i >= ivm_pkg::VEC_TA0 && i < ivm_pkg::VEC_TA0 + ivm_pkg::TA_NUM)
        begin : g_ta0
            assign vld[i] = 1'b1;
            if (i == ivm_pkg::VEC_TA0 + ivm_pkg::TO_HUNF) begin : g_h
                // High underflow exists only in split mode
                assign ev[i] = s_r.sp0 & timer_a0_split_evt[i - ivm_pkg::VEC_TA0];
            end else begin : g_o
                assign ev[i] = s_r.sp0 ? timer_a0_split_evt[i - ivm_pkg::VEC_TA0] :
                    evt_in[i];
            end
            assign ena[i] = s_r.en[i];
            assign gate[i] = s_r.ge;
        end else if (i >= ivm_pkg::VEC_TA1 && i < ivm_pkg::VEC_TA1 + ivm_pkg::TA_NUM)
        begin : g_ta1
            assign vld[i] = 1'b1;
            if (i == ivm_pkg::VEC_TA1 + ivm_pkg::TO_HUNF) begin : g_h
                assign ev[i] = s_r.sp1 & timer_a1_split_evt[i - ivm_pkg::VEC_TA1];
            end else begin : g_o
                assign ev[i] = s_r.sp1 ? timer_a1_split_evt[i - ivm_pkg::VEC_TA1] :
                    evt_in[i];
            end
            assign ena[i] = s_r.en[i];
            assign gate[i] = s_r.ge;
        end else begin : g_gen
            // One input line per vector, so no vector has two owners
            assign vld[i] = 1'b1;
            assign ev[i] = evt_in[i];
            assign ena[i] = s_r.en[i];
            assign gate[i] = s_r.ge;
        end
    end

    // Enable, flag and global gate must all hold
    assign pend_cur = s_r.flg & ena & gate;

    lowest_set_finder #(
        .W(VW),
        .IW(IW)
    ) u_find (
        .bits(pend_cur),
        .found(found),
        .idx(low_idx)
    );

    // Override only wins when its vector is really pending
    assign vec_sel = (s_r.ovr && pend_cur[s_r.pv]) ? s_r.pv : low_idx;

    always_comb begin
        s_nxt = s_r;
        clr = '0;
        if (acc_wr) begin
            case (paddr)
                ivm_pkg::OFS_CTRL: begin
                    s_nxt.ge = pwdata[ivm_pkg::CB_GE];
                    s_nxt.sp0 = pwdata[ivm_pkg::CB_SP0];
                    s_nxt.sp1 = pwdata[ivm_pkg::CB_SP1];
                    s_nxt.ovr = pwdata[ivm_pkg::CB_OVR];
                    s_nxt.pv = pwdata[ivm_pkg::CB_PV_LO +: IW];
                end
                ivm_pkg::OFS_EN_LO: begin
                    s_nxt.en[WD-1:0] = pwdata & vld[WD-1:0];
                end
                ivm_pkg::OFS_EN_HI: begin
                    s_nxt.en[VW-1:WD] = pwdata & vld[VW-1:WD];
                end
                ivm_pkg::OFS_FLG_LO: begin
                    clr[WD-1:0] = pwdata;
                end
                ivm_pkg::OFS_FLG_HI: begin
                    clr[VW-1:WD] = pwdata;
                end
                default: begin
                end
            endcase
        end
        // Set wins over a clear in the same cycle; flag is kept regardless of enable
        s_nxt.flg = ((s_r.flg & ~clr) | ev) & vld;
        // Request follows the pending set one cycle later; acceptance is not an input
        s_nxt.req = found;
        s_nxt.vec = found ? vec_sel : '0;
        s_nxt.wad = AW'(s_nxt.vec * ivm_pkg::WORD_STEP);
        if (setup) begin
            s_nxt.err = ~hit;
            s_nxt.rd = '0;
            case (paddr)
                ivm_pkg::OFS_CTRL: begin
                    s_nxt.rd[ivm_pkg::CB_GE] = s_r.ge;
                    s_nxt.rd[ivm_pkg::CB_SP0] = s_r.sp0;
                    s_nxt.rd[ivm_pkg::CB_SP1] = s_r.sp1;
                    s_nxt.rd[ivm_pkg::CB_OVR] = s_r.ovr;
                    s_nxt.rd[ivm_pkg::CB_PV_LO +: IW] = s_r.pv;
                end
                ivm_pkg::OFS_EN_LO: begin
                    s_nxt.rd = ena[WD-1:0];
                end
                ivm_pkg::OFS_EN_HI: begin
                    s_nxt.rd = ena[VW-1:WD];
                end
                ivm_pkg::OFS_FLG_LO: begin
                    s_nxt.rd = s_r.flg[WD-1:0];
                end
                ivm_pkg::OFS_FLG_HI: begin
                    s_nxt.rd = s_r.flg[VW-1:WD];
                end
                ivm_pkg::OFS_STAT: begin
                    s_nxt.rd[ivm_pkg::SB_REQ] = s_r.req;
                    s_nxt.rd[ivm_pkg::SB_VEC_LO +: IW] = s_r.vec;
                    s_nxt.rd[ivm_pkg::SB_WAD_LO +: AW] = s_r.wad;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Read data is caught in the setup cycle, so no wait states are needed
    assign pready = 1'b1;
    assign pslverr = s_r.err;
    assign prdata = s_r.rd;
    assign irq_req = s_r.req;
    assign irq_vector = s_r.vec;
    assign irq_word_addr = s_r.wad;

    // Helpers for the checks below
    logic [VW-1:0] below;
    assign below = (VW'(1) << irq_vector) - VW'(1);

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_flag_no_enable: assert property (
        (ev[ivm_pkg::VEC_SPI] && !s_r.en[ivm_pkg::VEC_SPI])
        |=> s_r.flg[ivm_pkg::VEC_SPI]
    ) else $error("flag not set while source disabled");

    a_enable_write: assert property (
        (acc_wr && paddr == ivm_pkg::OFS_EN_LO)
        |=> s_r.en[ivm_pkg::VEC_SPI] == $past(pwdata[ivm_pkg::VEC_SPI])
    ) else $error("enable bit did not take written value");

    a_req_needs_both: assert property (
        irq_req |-> (|($past(s_r.flg) & $past(ena)))
    ) else $error("request without enabled flag");

    a_req_holds: assert property (
        ((|pend_cur) && !acc_wr) |=> (|pend_cur) ##1 irq_req
    ) else $error("request dropped without flag clear");

    a_global_gate: assert property (
        (!s_r.ge && !s_r.flg[ivm_pkg::VEC_NMI]) |=> !irq_req
    ) else $error("maskable request without global enable");

    a_vec_owned: assert property (
        irq_req |-> (irq_vector < N_VEC && irq_vector != ivm_pkg::VEC_RESET)
    ) else $error("vector outside table or reset entry");

    a_nmi_entry: assert property (
        nmi_src |=> s_r.flg[ivm_pkg::VEC_NMI] ##1
        (irq_req && (irq_vector != ivm_pkg::VEC_NMI ||
        irq_word_addr == ivm_pkg::ADDR_NMI))
    ) else $error("non-maskable entry not raised at its word");

    a_ta0_split: assert property (
        (s_r.sp0 && timer_a0_split_evt[ivm_pkg::SE_HUNF])
        |=> s_r.flg[ivm_pkg::VEC_TA0 + ivm_pkg::TO_HUNF]
    ) else $error("first timer high underflow lost");

    a_ta0_normal: assert property (
        (!s_r.sp0 && !s_r.flg[ivm_pkg::VEC_TA0 + ivm_pkg::TO_HUNF] && !$past(s_r.sp0))
        |=> !s_r.flg[ivm_pkg::VEC_TA0 + ivm_pkg::TO_HUNF]
    ) else $error("high underflow flagged in normal mode");

    a_word_addr: assert property (
        irq_req |-> irq_word_addr == {irq_vector, 1'b0}
    ) else $error("word address does not match vector");

    a_ta1_compare: assert property (
        (!s_r.sp1 && evt_in[ivm_pkg::VEC_TA1 + ivm_pkg::TO_CMP0])
        |=> s_r.flg[ivm_pkg::VEC_TA1 + ivm_pkg::TO_CMP0]
    ) else $error("second timer compare flag lost");

    a_spi_vector: assert property (
        (irq_req && irq_vector == ivm_pkg::VEC_SPI) |-> irq_word_addr == ivm_pkg::ADDR_SPI
    ) else $error("serial interface vector at wrong word");

    a_lowest_first: assert property (
        ((|pend_cur) && !s_r.ovr) |=> irq_req && (($past(pend_cur) & below) == '0)
    ) else $error("lower pending vector was skipped");

    // Flag checks look at the raw state s_r.flg; request checks look at the irq_req output
    a_flag_sticky: assert property (
        (s_r.flg[ivm_pkg::VEC_SPI] && !(acc_wr && paddr == ivm_pkg::OFS_FLG_LO))
        |=> s_r.flg[ivm_pkg::VEC_SPI]
    ) else $error("flag lost without a clear");

    a_flag_clear: assert property (
        (acc_wr && paddr == ivm_pkg::OFS_FLG_LO && pwdata[ivm_pkg::VEC_SPI] &&
        !ev[ivm_pkg::VEC_SPI])
        |=> !s_r.flg[ivm_pkg::VEC_SPI]
    ) else $error("flag survived its clear");

    a_no_pend_idle: assert property (
        (pend_cur == '0) |=> !irq_req
    ) else $error("request without a pending source");

    a_pend_raises: assert property (
        (|pend_cur) |=> irq_req
    ) else $error("pending source raised no request");

    // Vector zero is the reset entry and stands on the outputs whenever nothing is asked
    a_idle_zero: assert property (
        !irq_req |-> (irq_vector == ivm_pkg::VEC_RESET &&
        irq_word_addr == ivm_pkg::ADDR_RESET)
    ) else $error("idle outputs not at the reset entry");

    a_nmi_word: assert property (
        (irq_req && irq_vector == ivm_pkg::VEC_NMI) |-> irq_word_addr == ivm_pkg::ADDR_NMI
    ) else $error("non-maskable vector at wrong word");

    a_nmi_first: assert property (
        (s_r.flg[ivm_pkg::VEC_NMI] && !s_r.ovr)
        |=> irq_req && irq_vector == ivm_pkg::VEC_NMI
    ) else $error("non-maskable entry not presented first");

    // Split mode takes timer events from the split ports only
    a_ta0_split_ignore: assert property (
        (s_r.sp0 && evt_in[ivm_pkg::VEC_TA0] && !timer_a0_split_evt[ivm_pkg::SE_LUNF] &&
        !s_r.flg[ivm_pkg::VEC_TA0])
        |=> !s_r.flg[ivm_pkg::VEC_TA0]
    ) else $error("normal overflow flagged in split mode");

    a_ta0_compare: assert property (
        (s_r.sp0 && timer_a0_split_evt[ivm_pkg::TO_CMP0])
        |=> s_r.flg[ivm_pkg::VEC_TA0 + ivm_pkg::TO_CMP0]
    ) else $error("first timer low compare lost");

    a_ta1_split: assert property (
        (s_r.sp1 && timer_a1_split_evt[ivm_pkg::SE_HUNF])
        |=> s_r.flg[ivm_pkg::VEC_TA1 + ivm_pkg::TO_HUNF]
    ) else $error("second timer high underflow lost");

    a_override_wins: assert property (
        (s_r.ovr && pend_cur[s_r.pv])
        |=> irq_req && irq_vector == $past(s_r.pv)
    ) else $error("pending override vector not presented");

    a_en_hi_write: assert property (
        (acc_wr && paddr == ivm_pkg::OFS_EN_HI)
        |=> s_r.en[ivm_pkg::VEC_TA1] == $past(pwdata[ivm_pkg::VEC_TA1 - ivm_pkg::WORD])
    ) else $error("upper enable bit did not take written value");

endmodule : interrupt_vector_mapping
`default_nettype wire

// ---- ivm_pkg.sv ----
// Constants for the interrupt request and vector mapping block.
// Assumes one clock domain and an APB master with 32-bit data.
package ivm_pkg;
    localparam int VEC_W = 64;
    localparam int N_VEC = 45;
    localparam int IDX_W = 6;
    localparam int WAD_W = 7;
    localparam int ADDR_W = 8;
    localparam int WORD = 32;
    localparam int WORD_STEP = 2;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_EN_LO = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_EN_HI = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_FLG_LO = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_FLG_HI = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_STAT = 8'h14;
    localparam int CB_GE = 0;
    localparam int CB_SP0 = 1;
    localparam int CB_SP1 = 2;
    localparam int CB_OVR = 3;
    localparam int CB_PV_LO = 8;
    localparam int SB_REQ = 0;
    localparam int SB_VEC_LO = 8;
    localparam int SB_WAD_LO = 16;
    localparam int VEC_RESET = 0;
    localparam int VEC_NMI = 1;
    localparam int VEC_TA0 = 8;
    localparam int VEC_SPI = 17;
    localparam int VEC_TA1 = 38;
    localparam int TA_NUM = 5;
    localparam int TO_HUNF = 1;
    localparam int TO_CMP0 = 2;
    localparam int SE_LUNF = 0;
    localparam int SE_HUNF = 1;
    localparam logic [WAD_W-1:0] ADDR_RESET = 7'h00;
    localparam logic [WAD_W-1:0] ADDR_NMI = 7'h02;
    localparam logic [WAD_W-1:0] ADDR_SPI = 7'h22;
endpackage : ivm_pkg

// ---- lowest_set_finder.sv ----
// Finds the lowest set bit of a vector.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
`default_nettype none
module lowest_set_finder #(
    parameter int W = 64,
    parameter int IW = 6
) (
    input wire logic [W-1:0] bits,
    output logic found,
    output logic [IW-1:0] idx
);
    always_comb begin
        found = 1'b0;
        idx = '0;
        // Scan downward so the lowest set bit is the last one kept
        for (int i = W - 1; i >= 0; i--) begin
            if (bits[i]) begin
                found = 1'b1;
                idx = IW'(i);
            end
        end
    end
endmodule : lowest_set_finder
`default_nettype wire

// ---- tb_interrupt_vector_mapping.sv ----
// Self-checking bench for the interrupt request and vector mapping block.
// Assumes ivm_pkg, the design files and core_fetch are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_interrupt_vector_mapping;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, msc = 1'b0, cfd = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, irq_req, err;
    logic [44:0] evt_in = '0;
    logic [4:0] sa0 = 5'h00, sa1 = 5'h00;
    logic [5:0] irq_vector;
    logic [6:0] irq_word_addr, fetch_addr;
    int error_cnt = 0, checks_done = 0, cyc = 0;

    interrupt_vector_mapping dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt_in(evt_in),
        .timer_a0_split_evt(sa0), .timer_a1_split_evt(sa1), .memory_scan_checker(msc),
        .clock_failure_detector(cfd), .irq_req(irq_req), .irq_vector(irq_vector),
        .irq_word_addr(irq_word_addr));
    core_fetch core (.pclk(pclk), .presetn(presetn), .irq_req(irq_req),
        .irq_word_addr(irq_word_addr), .fetch_addr(fetch_addr));

    always #5 pclk = ~pclk;

    task automatic test_done();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    // Hang guard: the whole sequence needs well under 3000 cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            test_done();
        end
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Sources: 0 event vector, 1 and 2 split timers, 3 scan checker, 4 clock failure
    task automatic pulse(input int s, input int i);
        @(posedge pclk);
        case (s)
            0: evt_in[i] <= 1'b1;
            1: sa0[i] <= 1'b1;
            2: sa1[i] <= 1'b1;
            3: msc <= 1'b1;
            default: cfd <= 1'b1;
        endcase
        @(posedge pclk);
        evt_in <= '0;
        sa0 <= 5'h00;
        sa1 <= 5'h00;
        msc <= 1'b0;
        cfd <= 1'b0;
    endtask : pulse

    // Vector and word address go out one cycle after the flag; the core latches a cycle later
    task automatic chk(input logic r, input int v);
        repeat (2) @(posedge pclk);
        #1;
        cmp({31'h0, irq_req}, {31'h0, r});
        cmp({26'h0, irq_vector}, v);
        cmp({25'h0, irq_word_addr}, 2 * v);
        if (r) cmp({25'h0, fetch_addr}, 2 * v);
    endtask : chk

    task automatic clr(input int v);
        apb(1'b1, (v < 32) ? 8'h0C : 8'h10, 32'h1 << (v % 32));
    endtask : clr

    task automatic t_gate();
        apb(1'b0, 8'h14, 32'h0);
        cmp(rd, 32'h0);
        pulse(0, 17);
        apb(1'b0, 8'h0C, 32'h0);
        cmp(rd, 32'h0002_0000);
        chk(1'b0, 0);
        apb(1'b1, 8'h04, 32'h0002_0000);
        chk(1'b0, 0);
        apb(1'b1, 8'h00, 32'h1);
        chk(1'b1, 17);
        repeat (20) @(posedge pclk);
        chk(1'b1, 17);
        apb(1'b1, 8'h04, 32'h0);
        chk(1'b0, 0);
        apb(1'b1, 8'h04, 32'h0002_0000);
        clr(17);
        chk(1'b0, 0);
    endtask : t_gate

    task automatic t_map();
        logic r;
        apb(1'b1, 8'h04, 32'hFFFF_FFFF);
        apb(1'b1, 8'h08, 32'hFFFF_FFFF);
        for (int v = 0; v < 45; v++) begin
            r = !(v < 2 || v == 9 || v == 39);
            pulse(0, v);
            chk(r, r ? v : 0);
            clr(v);
        end
        apb(1'b1, 8'h00, 32'h7);
        pulse(0, 8);
        chk(1'b0, 0);
        for (int k = 0; k < 5; k++) begin
            pulse(1, k);
            chk(1'b1, 8 + k);
            clr(8 + k);
            pulse(2, k);
            chk(1'b1, 38 + k);
            clr(38 + k);
        end
    endtask : t_map

    task automatic t_prio();
        apb(1'b1, 8'h00, 32'h1);
        pulse(0, 40);
        pulse(0, 10);
        chk(1'b1, 10);
        clr(10);
        chk(1'b1, 40);
        apb(1'b1, 8'h00, 32'h0000_2809);
        pulse(0, 10);
        chk(1'b1, 40);
        clr(40);
        clr(10);
        chk(1'b0, 0);
    endtask : t_prio

    task automatic t_nmi();
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h04, 32'h0);
        for (int s = 3; s < 5; s++) begin
            pulse(s, 0);
            chk(1'b1, 1);
            clr(1);
            chk(1'b0, 0);
        end
        apb(1'b0, 8'h3C, 32'h0);
        cmp({31'h0, err}, 32'h1);
        cmp(rd, 32'h0);
    endtask : t_nmi

    // Reset in mid-run with a request standing: every output falls back at once
    task automatic t_reset();
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b1, 8'h04, 32'h0002_0000);
        pulse(0, 17);
        chk(1'b1, 17);
        @(posedge pclk);
        presetn <= 1'b0;
        #1;
        cmp({29'h0, irq_req, pslverr, pready}, 32'h1);
        cmp({19'h0, irq_vector, irq_word_addr}, 32'h0);
        cmp(prdata, 32'h0);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h0C, 32'h0);
        cmp(rd, 32'h0);
        pulse(0, 17);
        chk(1'b0, 0);
    endtask : t_reset

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_gate();
        t_map();
        t_prio();
        t_nmi();
        t_reset();
        test_done();
    end
endmodule : tb_interrupt_vector_mapping
`default_nettype wire
